//--- include/ebie_pkg.sv
// Constants for the block interrupt enable logic of one channel.
// Assumes a byte-wide register port with read data one cycle after the strobe.
// Summary of operation
// - Bit 7 gates every national-bit block request onto the interrupt output.
// - Block enable alone raises nothing; the source-level enable must also be set.
// - Bit 5 enables the recovered-clock-loss source interrupt.
// - Bit 4 enables the one-second periodic source interrupt.
// - Bit 3 gates every data-link block request.
// - Bit 2 gates every slip buffer block request.
// - Bit 1 gates every alarm and error block request.
// - Bit 0 gates every framer block request.
// - A block pending bit clears when the host reads that block's source status register in a cycle with no gated request.
package ebie_pkg;
    // ==========================================
    // Register map
    localparam logic [3:0] EBIE_ADDR_ENABLE = 4'h1;
    localparam logic [3:0] EBIE_ADDR_STATUS = 4'h0;
    localparam logic [3:0] EBIE_ADDR_EVENT = 4'h2;
    localparam logic [3:0] EBIE_ADDR_MASK = 4'h3;
    localparam logic [7:0] EBIE_ENABLE_RESET = 8'h00;
    localparam logic [7:0] EBIE_ENABLE_WMASK = 8'hbf;
    localparam logic [7:0] EBIE_ZERO = 8'h00;
    // ==========================================
    // Bit positions
    localparam int EBIE_BIT_NATBIT = 7;
    localparam int EBIE_BIT_CLKLOSS = 5;
    localparam int EBIE_BIT_ONESEC = 4;
    localparam int EBIE_BIT_DLINK = 3;
    localparam int EBIE_BIT_SLIP = 2;
    localparam int EBIE_BIT_ALARM = 1;
    localparam int EBIE_BIT_FRAMER = 0;
    localparam int EBIE_NUM_BLOCKS = 8;
endpackage

//--- core/ebie_pending.sv
// One pending bit per block, set by the block's gated request, cleared by a status read.
// Assumes requests and clear pulses come from logic on the same clock.
`timescale 1ns/1ps
module ebie_pending
    import ebie_pkg::*;
#(
    parameter int WIDTH = EBIE_NUM_BLOCKS
) (
    // Clock and reset
    input wire logic clock,
    input wire logic sys_rst,
    // Requests and clears
    input wire logic [WIDTH-1:0] req,
    input wire logic [WIDTH-1:0] clr,
    // Pending
    output logic [WIDTH-1:0] pend
);
    logic [WIDTH-1:0] pend_q;
    logic [WIDTH-1:0] pend_d;

    // Set beats clear so a request in the clearing cycle stays visible
    assign pend_d = req | (pend_q & ~clr);
    assign pend = pend_q;

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            pend_q <= '0;
        end else begin
            pend_q <= pend_d;
        end
    end

    pend_clr_a: assert property (@(posedge clock) disable iff (sys_rst)
        (clr[0] && !req[0]) |=> !pend_q[0]) else $error("pending not cleared by read");
endmodule

//--- core/ebie_core.sv
// Block interrupt enable register with gated block requests and interrupt output.
// Assumes block and source requests are synchronous levels from on-chip logic.
`timescale 1ns/1ps
module ebie_core
    import ebie_pkg::*;
(
    // Clock and reset
    input wire logic clock,
    input wire logic sys_rst,
    // Register port
    input wire logic [3:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    // Block requests, already gated by each block's own source enables
    input wire logic [7:0] block_req,
    // Raw source requests for clock loss and one second
    input wire logic clock_loss_src,
    input wire logic one_second_src,
    // Source status register reads per block
    input wire logic [7:0] block_status_read,
    // Enables out to blocks
    output logic national_bit_block_int_enable,
    output logic recovered_clock_loss_int_enable,
    output logic one_second_int_enable,
    output logic data_link_block_int_enable,
    output logic slip_buffer_block_int_enable,
    output logic alarm_error_block_int_enable,
    output logic framer_block_int_enable,
    // Interrupt
    output logic int_req
);
    // ==========================================
    // Registers
    logic [7:0] block_interrupt_enable_q;
    logic [7:0] block_interrupt_enable_d;
    logic [7:0] event_q;
    logic [7:0] event_d;
    logic [7:0] mask_q;
    logic [7:0] mask_d;
    logic [7:0] rdata_q;
    logic [7:0] rdata_d;
    logic [7:0] gated_req;
    logic [7:0] pend;
    logic [7:0] pend_rise;
    logic [7:0] pend_prev_q;
    logic [7:0] unmasked;
    logic wr_enable;
    logic wr_event;
    logic wr_mask;
    logic rd_hit;

    assign wr_enable = reg_wr && (reg_addr == EBIE_ADDR_ENABLE);
    assign wr_event = reg_wr && (reg_addr == EBIE_ADDR_EVENT);
    assign wr_mask = reg_wr && (reg_addr == EBIE_ADDR_MASK);
    assign rd_hit = reg_rd;

    // Bit 6 is reserved in this mode and stays zero
    assign block_interrupt_enable_d = wr_enable ? (reg_wdata & EBIE_ENABLE_WMASK) : block_interrupt_enable_q;
    assign mask_d = wr_mask ? reg_wdata : mask_q;

    // ==========================================
    // Gating per block
    genvar g;
    generate
        for (g = 0; g < EBIE_NUM_BLOCKS; g++) begin : gen_gate
            if (g == EBIE_BIT_CLKLOSS) begin : gen_clk
                assign gated_req[g] = clock_loss_src && block_interrupt_enable_q[g];
            end else if (g == EBIE_BIT_ONESEC) begin : gen_sec
                assign gated_req[g] = one_second_src && block_interrupt_enable_q[g];
            end else begin : gen_blk
                assign gated_req[g] = block_req[g] && block_interrupt_enable_q[g];
            end
        end
    endgenerate

    ebie_pending #(
        .WIDTH(EBIE_NUM_BLOCKS)
    ) u_pending (
        .clock(clock),
        .sys_rst(sys_rst),
        .req(gated_req),
        .clr(block_status_read),
        .pend(pend)
    );

    // Sticky event bits record new pending rises; write one clears, set wins
    assign pend_rise = pend & ~pend_prev_q;
    assign event_d = pend_rise | (event_q & ~(wr_event ? reg_wdata : EBIE_ZERO));
    assign unmasked = event_q & mask_q;

    // Status reflects live pending; the pin follows the block bits or any unmasked event bit
    assign int_req = (|pend) || (|unmasked);

    assign rdata_d = !rd_hit ? EBIE_ZERO :
                     (reg_addr == EBIE_ADDR_ENABLE) ? block_interrupt_enable_q :
                     (reg_addr == EBIE_ADDR_STATUS) ? pend :
                     (reg_addr == EBIE_ADDR_EVENT) ? event_q :
                     (reg_addr == EBIE_ADDR_MASK) ? mask_q : EBIE_ZERO;

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            block_interrupt_enable_q <= EBIE_ENABLE_RESET;
            event_q <= EBIE_ZERO;
            mask_q <= EBIE_ZERO;
            rdata_q <= EBIE_ZERO;
            pend_prev_q <= EBIE_ZERO;
        end else begin
            block_interrupt_enable_q <= block_interrupt_enable_d;
            event_q <= event_d;
            mask_q <= mask_d;
            rdata_q <= rdata_d;
            pend_prev_q <= pend;
        end
    end

    assign reg_rdata = rdata_q;
    assign national_bit_block_int_enable = block_interrupt_enable_q[EBIE_BIT_NATBIT];
    assign recovered_clock_loss_int_enable = block_interrupt_enable_q[EBIE_BIT_CLKLOSS];
    assign one_second_int_enable = block_interrupt_enable_q[EBIE_BIT_ONESEC];
    assign data_link_block_int_enable = block_interrupt_enable_q[EBIE_BIT_DLINK];
    assign slip_buffer_block_int_enable = block_interrupt_enable_q[EBIE_BIT_SLIP];
    assign alarm_error_block_int_enable = block_interrupt_enable_q[EBIE_BIT_ALARM];
    assign framer_block_int_enable = block_interrupt_enable_q[EBIE_BIT_FRAMER];

    // ==========================================
    // Checks
    natbit_gate_a: assert property (@(posedge clock) disable iff (sys_rst)
        !block_interrupt_enable_q[EBIE_BIT_NATBIT] |-> !gated_req[EBIE_BIT_NATBIT]) else $error("natbit leak");
    enable_alone_a: assert property (@(posedge clock) disable iff (sys_rst)
        (block_req == EBIE_ZERO && !clock_loss_src && !one_second_src && pend == EBIE_ZERO)
        |=> pend == EBIE_ZERO) else $error("enable alone raised pending");
    clkloss_gate_a: assert property (@(posedge clock) disable iff (sys_rst)
        (clock_loss_src && block_interrupt_enable_q[EBIE_BIT_CLKLOSS]) |=> pend[EBIE_BIT_CLKLOSS])
        else $error("clock loss not pending");
    onesec_gate_a: assert property (@(posedge clock) disable iff (sys_rst)
        (!one_second_src || !block_interrupt_enable_q[EBIE_BIT_ONESEC]) |-> !gated_req[EBIE_BIT_ONESEC])
        else $error("one second leak");
    dlink_gate_a: assert property (@(posedge clock) disable iff (sys_rst)
        (block_req[EBIE_BIT_DLINK] && block_interrupt_enable_q[EBIE_BIT_DLINK]) |=> int_req)
        else $error("data link not raised");
    slip_gate_a: assert property (@(posedge clock) disable iff (sys_rst)
        !block_interrupt_enable_q[EBIE_BIT_SLIP] |-> !gated_req[EBIE_BIT_SLIP]) else $error("slip leak");
    alarm_gate_a: assert property (@(posedge clock) disable iff (sys_rst)
        (block_req[EBIE_BIT_ALARM] && block_interrupt_enable_q[EBIE_BIT_ALARM]) |=> pend[EBIE_BIT_ALARM])
        else $error("alarm not pending");
    framer_gate_a: assert property (@(posedge clock) disable iff (sys_rst)
        !block_interrupt_enable_q[EBIE_BIT_FRAMER] |-> !gated_req[EBIE_BIT_FRAMER]) else $error("framer leak");
    enable_write_a: assert property (@(posedge clock) disable iff (sys_rst)
        wr_enable |=> block_interrupt_enable_q == $past(reg_wdata & EBIE_ENABLE_WMASK))
        else $error("enable write lost");
    int_level_a: assert property (@(posedge clock) disable iff (sys_rst)
        (pend != EBIE_ZERO) |-> int_req) else $error("interrupt low while pending");
    read_data_a: assert property (@(posedge clock) disable iff (sys_rst)
        (reg_rd && reg_addr == EBIE_ADDR_ENABLE) |=> reg_rdata == $past(block_interrupt_enable_q))
        else $error("read data wrong");

    // ==========================================
    // Gating checks in the opposite direction for every enable bit
    natbit_pend_a: assert property (@(posedge clock) disable iff (sys_rst)
        (block_req[EBIE_BIT_NATBIT] && block_interrupt_enable_q[EBIE_BIT_NATBIT]) |=> pend[EBIE_BIT_NATBIT])
        else $error("natbit not pending");
    clkloss_block_a: assert property (@(posedge clock) disable iff (sys_rst)
        !block_interrupt_enable_q[EBIE_BIT_CLKLOSS] |-> !gated_req[EBIE_BIT_CLKLOSS])
        else $error("clock loss leak");
    onesec_pend_a: assert property (@(posedge clock) disable iff (sys_rst)
        (one_second_src && block_interrupt_enable_q[EBIE_BIT_ONESEC]) |=> pend[EBIE_BIT_ONESEC])
        else $error("one second not pending");
    dlink_block_a: assert property (@(posedge clock) disable iff (sys_rst)
        !block_interrupt_enable_q[EBIE_BIT_DLINK] |-> !gated_req[EBIE_BIT_DLINK])
        else $error("data link leak");
    slip_pend_a: assert property (@(posedge clock) disable iff (sys_rst)
        (block_req[EBIE_BIT_SLIP] && block_interrupt_enable_q[EBIE_BIT_SLIP]) |=> pend[EBIE_BIT_SLIP])
        else $error("slip not pending");
    alarm_block_a: assert property (@(posedge clock) disable iff (sys_rst)
        !block_interrupt_enable_q[EBIE_BIT_ALARM] |-> !gated_req[EBIE_BIT_ALARM])
        else $error("alarm leak");
    framer_pend_a: assert property (@(posedge clock) disable iff (sys_rst)
        (block_req[EBIE_BIT_FRAMER] && block_interrupt_enable_q[EBIE_BIT_FRAMER]) |=> pend[EBIE_BIT_FRAMER])
        else $error("framer not pending");
    // A request in the clearing cycle wins, so only a quiet request may clear
    status_clear_a: assert property (@(posedge clock) disable iff (sys_rst)
        (block_status_read[EBIE_BIT_SLIP] && !gated_req[EBIE_BIT_SLIP]) |=> !pend[EBIE_BIT_SLIP])
        else $error("slip pending not cleared");

    // ==========================================
    // Register and interrupt output checks
    reserved_zero_a: assert property (@(posedge clock) disable iff (sys_rst)
        (block_interrupt_enable_q & ~EBIE_ENABLE_WMASK) == EBIE_ZERO)
        else $error("reserved enable bit set");
    int_quiet_a: assert property (@(posedge clock) disable iff (sys_rst)
        (pend == EBIE_ZERO && unmasked == EBIE_ZERO) |-> !int_req)
        else $error("interrupt high while idle");
    // Write one clears, but a rise in the same cycle keeps its bit
    event_clear_a: assert property (@(posedge clock) disable iff (sys_rst)
        (wr_event && pend_rise == EBIE_ZERO) |=> (event_q & $past(reg_wdata)) == EBIE_ZERO)
        else $error("event not cleared");
    event_set_a: assert property (@(posedge clock) disable iff (sys_rst)
        (pend_rise != EBIE_ZERO) |=> (event_q & $past(pend_rise)) == $past(pend_rise))
        else $error("event rise lost");
    // Read data is zero outside the answer cycle, so stale values never leak
    idle_rdata_a: assert property (@(posedge clock) disable iff (sys_rst)
        !reg_rd |=> reg_rdata == EBIE_ZERO)
        else $error("read data not idle");
    status_read_a: assert property (@(posedge clock) disable iff (sys_rst)
        (reg_rd && reg_addr == EBIE_ADDR_STATUS) |=> reg_rdata == $past(pend))
        else $error("status read wrong");
    mask_write_a: assert property (@(posedge clock) disable iff (sys_rst)
        wr_mask |=> mask_q == $past(reg_wdata))
        else $error("mask write lost");

    // ==========================================
    // Covers
    cov_natbit_c: cover property (@(posedge clock) gated_req[EBIE_BIT_NATBIT] ##1 int_req);
    cov_clear_c: cover property (@(posedge clock) pend[EBIE_BIT_SLIP] ##1 block_status_read[EBIE_BIT_SLIP] ##1 !pend[EBIE_BIT_SLIP]);
    cov_onesec_c: cover property (@(posedge clock) gated_req[EBIE_BIT_ONESEC]);
    cov_event_c: cover property (@(posedge clock) (event_q != EBIE_ZERO) ##1 wr_event ##1 (event_q == EBIE_ZERO));
    cov_mask_c: cover property (@(posedge clock) (pend == EBIE_ZERO && unmasked != EBIE_ZERO) ##1 int_req);
endmodule

//--- sim/ebie_blocks_model.sv
// Far-side model of the blocks that raise requests.
// Assumes one-cycle raise and host_rd pulses on the same clock.
`timescale 1ns/1ps
module ebie_blocks_model (
    // Clock and reset
    input wire logic clock,
    input wire logic sys_rst,
    // Bench commands
    input wire logic [7:0] raise,
    input wire logic [7:0] host_rd,
    // Toward the core
    output logic [7:0] block_req,
    output logic [7:0] block_status_read
);
    logic [7:0] req_q;
    logic [7:0] rd_q;
    // ====================
    // Requests count as already gated by source enables
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            req_q <= 8'h00;
            rd_q <= 8'h00;
        end else begin
            req_q <= (req_q | raise) & ~host_rd;
            // Read pulse is registered to land in the same cycle as the drop, else set-wins keeps pending
            rd_q <= host_rd;
        end
    end
    assign block_req = req_q;
    assign block_status_read = rd_q;
endmodule

//--- sim/tb_top.sv
// Bench for the block interrupt enable core.
// Assumes the blocks model answers status reads one cycle late.
`timescale 1ns/1ps
module tb_top;
    import ebie_pkg::*;
    logic clock = 1'b0;
    logic sys_rst = 1'b1;
    logic [3:0] reg_addr = 4'h0;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [7:0] raise = 8'h00;
    logic [7:0] host_rd = 8'h00;
    logic [1:0] src = 2'b00;
    logic [7:0] reg_rdata, block_req, status_rd;
    logic int_req;
    wire [7:0] en;
    int n_mismatch = 0;
    int n_compared = 0;
    int cyc = 0;
    int blk[5] = '{7, 3, 2, 1, 0};
    always #50 clock = ~clock;
    assign en[6] = 1'b0;
    // ====================
    // Design and far side
    ebie_core u_ebie_core (.clock(clock), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .block_req(block_req),
        .clock_loss_src(src[1]), .one_second_src(src[0]), .block_status_read(status_rd),
        .national_bit_block_int_enable(en[7]), .recovered_clock_loss_int_enable(en[5]),
        .one_second_int_enable(en[4]), .data_link_block_int_enable(en[3]),
        .slip_buffer_block_int_enable(en[2]), .alarm_error_block_int_enable(en[1]),
        .framer_block_int_enable(en[0]), .int_req(int_req));
    ebie_blocks_model u_ebie_blocks_model (.clock(clock), .sys_rst(sys_rst), .raise(raise),
        .host_rd(host_rd), .block_req(block_req), .block_status_read(status_rd));
    // ====================
    // Tasks
    task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clock);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clock);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, output logic [7:0] d);
        @(posedge clock);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clock);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask
    task automatic pls(input logic [7:0] r, input logic [7:0] h);
        @(posedge clock);
        raise <= r;
        host_rd <= h;
        @(posedge clock);
        raise <= 8'h00;
        host_rd <= 8'h00;
    endtask
    task automatic drive_src(input logic [1:0] v);
        @(posedge clock);
        src <= v;
    endtask
    task automatic summarize;
        $display("compared %0d mismatched %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    // Hang guard, well above the roughly 155 cycles needed
    always @(posedge clock) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            n_mismatch++;
            summarize();
        end
    end
    // ====================
    // Tests
    initial begin
        logic [7:0] d;
        logic [7:0] m;
        logic [1:0] v;
        repeat (3) @(posedge clock);
        sys_rst <= 1'b0;
        rd(EBIE_ADDR_ENABLE, d);
        chk("enable reset", d, 8'h00);
        wr(EBIE_ADDR_ENABLE, 8'hff);
        rd(EBIE_ADDR_ENABLE, d);
        chk("enable rw", d, 8'hbf);
        chk("enable outs", en, 8'hbf);
        wr(4'hf, 8'hff);
        rd(4'hf, d);
        chk("unmapped read", d, 8'h00);
        foreach (blk[i]) begin
            m = 8'h01 << blk[i];
            wr(EBIE_ADDR_ENABLE, 8'hbf ^ m);
            pls(m, 8'h00);
            tick(2);
            chk("block off", int_req, 1'b0);
            wr(EBIE_ADDR_ENABLE, m);
            tick(2);
            chk("block on", int_req, 1'b1);
            rd(EBIE_ADDR_STATUS, d);
            chk("pending", d, m);
            pls(8'h00, m);
            tick(2);
            chk("serviced", int_req, 1'b0);
        end
        // Every block above rose once, so its sticky event bit must be set
        rd(EBIE_ADDR_EVENT, d);
        chk("block events", d, 8'h8f);
        wr(EBIE_ADDR_EVENT, 8'hff);
        wr(EBIE_ADDR_MASK, 8'hff);
        wr(EBIE_ADDR_ENABLE, 8'hbf);
        tick(2);
        chk("enable alone", int_req, 1'b0);
        for (int k = 4; k < 6; k++) begin
            m = 8'h01 << k;
            v = (k == 5) ? 2'b10 : 2'b01;
            wr(EBIE_ADDR_ENABLE, 8'h00);
            drive_src(v);
            tick(2);
            chk("source off", int_req, 1'b0);
            drive_src(2'b00);
            wr(EBIE_ADDR_ENABLE, m);
            drive_src(v);
            tick(2);
            chk("source on", int_req, 1'b1);
            drive_src(2'b00);
            rd(EBIE_ADDR_EVENT, d);
            chk("source event", d, m);
            // Pending is sticky, so it must be serviced before the mask alone decides
            wr(EBIE_ADDR_MASK, 8'h00);
            pls(8'h00, m);
            tick(2);
            chk("masked", int_req, 1'b0);
            wr(EBIE_ADDR_MASK, 8'hff);
            tick(1);
            chk("unmasked", int_req, 1'b1);
            wr(EBIE_ADDR_EVENT, 8'hff);
            tick(1);
            chk("event cleared", int_req, 1'b0);
        end
        summarize();
    end
endmodule
